/* File: logic/pcs_pkg.sv */
// constants and types shared by the pll clock setup control block
package pcs_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] PCS_ADDR_FEEDBACK = 16'hf000;
  localparam logic [15:0] PCS_ADDR_PRESCALE = 16'hf001;
  localparam logic [15:0] PCS_ADDR_SOURCE = 16'hf002;
  localparam logic [15:0] PCS_ADDR_ENABLE = 16'hf003;
  localparam logic [15:0] PCS_ADDR_LOCK = 16'hf004;
  localparam logic [15:0] PCS_ADDR_CLKOUT = 16'hf005;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int PCS_DATA_W = 16;
  localparam int PCS_FB_W = 7;
  localparam int PCS_PRE_W = 2;
  localparam int PCS_CLKOUT_W = 3;
  localparam int PCS_SRC_BIT = 0;
  localparam int PCS_ENABLE_BIT = 0;
  localparam int PCS_LOCK_BIT = 0;
  localparam int PCS_CLKOUT_EN_BIT = 0;
  localparam int PCS_CLKOUT_RATE_LSB = 1;
  localparam logic [6:0] PCS_FB_RESET = 7'h60;
  localparam logic [1:0] PCS_PRE_RESET = 2'h0;
  localparam logic [2:0] PCS_CLKOUT_RESET = 3'h0;
  localparam logic PCS_SRC_RESET = 1'b0;
  localparam int PCS_PRE_CNT_W = 3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int PCS_CLK_PERIOD_NS = 25;
  localparam int PCS_REF_TIMEOUT_NS = 10000;
  localparam int PCS_REF_TIMEOUT_CYCLES =
    (PCS_REF_TIMEOUT_NS + PCS_CLK_PERIOD_NS - 1) / PCS_CLK_PERIOD_NS;
  localparam int PCS_LOCK_SETTLE_TICKS = 1024;

  // ----------------------------------------------------------------
  // lock state machine
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PCS_IDLE = 2'b00,
    PCS_ACQUIRE = 2'b01,
    PCS_LOCKED = 2'b10
  } pcs_lock_e;

endpackage : pcs_pkg

/* File: logic/pcs_ref_prescaler.sv */
// master clock pin synchroniser and reference prescale divider
`timescale 1ns/100ps
`default_nettype none

module pcs_ref_prescaler (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic masterClockInputPin,
  input wire logic [pcs_pkg::PCS_PRE_W-1:0] divSel,
  input wire logic restart,
  output logic refTick
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic sync3;
    logic [pcs_pkg::PCS_PRE_CNT_W-1:0] edgeCnt;
    logic refTick;
  } pcs_pre_state_s;

  pcs_pre_state_s st;
  pcs_pre_state_s next_st;
  logic pinEdge;
  logic [pcs_pkg::PCS_PRE_CNT_W-1:0] lastCount;

  assign pinEdge = st.sync2 & ~st.sync3;
  // divide by 1, 2, 4 or 8
  assign lastCount = pcs_pkg::PCS_PRE_CNT_W'((4'h1 << divSel) - 4'h1);

  always_comb begin
    next_st = st;
    next_st.sync1 = masterClockInputPin;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    next_st.refTick = 1'b0;
    if (restart) begin
      next_st.edgeCnt = '0;
    end else if (pinEdge) begin
      if (st.edgeCnt == lastCount) begin
        next_st.edgeCnt = '0;
        next_st.refTick = 1'b1;
      end else begin
        next_st.edgeCnt = st.edgeCnt + 3'h1;
      end
    end
    if (srst) begin
      next_st = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    st <= next_st;
  end

  assign refTick = st.refTick;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_DIV_COUNT: assert property (@(posedge ref_clk) disable iff (srst)
    refTick |-> $past(pinEdge) && ($past(st.edgeCnt) == $past(lastCount)))
    else $error("reference tick without a full prescale count");

  AST_DIV8_SPACING: assert property (@(posedge ref_clk) disable iff (srst)
    (refTick && divSel == 2'h3 && !restart) |=> !refTick [*2])
    else $error("divide by eight ticks too close together");

endmodule : pcs_ref_prescaler

`default_nettype wire

/* File: logic/pcs_pll_clock_setup.sv */
// pll clock setup control: staged configuration, enable and lock flag
`timescale 1ns/100ps
`default_nettype none

module pcs_pll_clock_setup #(
  parameter int REF_TIMEOUT_CYCLES = pcs_pkg::PCS_REF_TIMEOUT_CYCLES,
  parameter int LOCK_SETTLE_TICKS = pcs_pkg::PCS_LOCK_SETTLE_TICKS
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [15:0] regAddr,
  input wire logic [pcs_pkg::PCS_DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [pcs_pkg::PCS_DATA_W-1:0] regRdData,
  input wire logic masterClockInputPin,
  output logic pllClockRun,
  output logic coreClockSourceSel,
  output logic [pcs_pkg::PCS_FB_W-1:0] feedbackMultiplier,
  output logic [pcs_pkg::PCS_PRE_W-1:0] activePrescale,
  output logic clkoutEnable,
  output logic [1:0] clkoutRate,
  output logic pllLockFlag
);

  localparam int TW = $clog2(REF_TIMEOUT_CYCLES + 1);
  localparam int SW = $clog2(LOCK_SETTLE_TICKS + 1);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  generate
    if (REF_TIMEOUT_CYCLES < 2 || LOCK_SETTLE_TICKS < 1) begin : gBadParam
      $error("timeout must be at least 2 cycles and settle at least 1 tick");
    end
  endgenerate

  typedef struct packed {
    logic [pcs_pkg::PCS_FB_W-1:0] fbStaged;
    logic [pcs_pkg::PCS_PRE_W-1:0] preStaged;
    logic srcStaged;
    logic [pcs_pkg::PCS_CLKOUT_W-1:0] clkoutStaged;
    logic enable;
    logic [pcs_pkg::PCS_FB_W-1:0] fbActive;
    logic [pcs_pkg::PCS_PRE_W-1:0] preActive;
    logic srcActive;
    logic [pcs_pkg::PCS_CLKOUT_W-1:0] clkoutActive;
    logic restartRef;
    pcs_pkg::pcs_lock_e lockState;
    logic [SW-1:0] settleCnt;
    logic [TW-1:0] refIdle;
    logic refStable;
    logic lockFlag;
    logic pllRun;
    logic [pcs_pkg::PCS_DATA_W-1:0] rdData;
  } pcs_state_s;

  pcs_state_s st;
  pcs_state_s next_st;
  logic refTick;
  logic enableRise;
  logic settingsValid;

  // ----------------------------------------------------------------
  // reference path
  // ----------------------------------------------------------------
  pcs_ref_prescaler uPrescaler (
    .ref_clk(ref_clk),
    .srst(srst),
    .masterClockInputPin(masterClockInputPin),
    .divSel(st.preActive),
    .restart(st.restartRef),
    .refTick(refTick)
  );

  assign enableRise = regWr && (regAddr == pcs_pkg::PCS_ADDR_ENABLE)
    && regWrData[pcs_pkg::PCS_ENABLE_BIT] && !st.enable;
  // a zero multiplier cannot close the loop
  assign settingsValid = (st.fbActive != '0);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.restartRef = 1'b0;
    next_st.rdData = '0;

    // configuration writes go to the staging copies only; the enable write takes effect directly
    if (regWr) begin
      unique case (regAddr)
        pcs_pkg::PCS_ADDR_FEEDBACK: next_st.fbStaged = regWrData[6:0];
        pcs_pkg::PCS_ADDR_PRESCALE: next_st.preStaged = regWrData[1:0];
        pcs_pkg::PCS_ADDR_SOURCE: next_st.srcStaged = regWrData[pcs_pkg::PCS_SRC_BIT];
        pcs_pkg::PCS_ADDR_ENABLE: next_st.enable = regWrData[pcs_pkg::PCS_ENABLE_BIT];
        pcs_pkg::PCS_ADDR_CLKOUT: next_st.clkoutStaged = regWrData[2:0];
        default: next_st.enable = st.enable; // lock register and holes ignore writes
      endcase
    end

    // apply staged settings on the zero-to-one enable edge
    if (enableRise) begin
      next_st.fbActive = st.fbStaged;
      next_st.preActive = st.preStaged;
      next_st.srcActive = st.srcStaged;
      next_st.clkoutActive = st.clkoutStaged;
      next_st.restartRef = 1'b1;
    end

    next_st.pllRun = next_st.enable;

    // reference watchdog
    if (refTick) begin
      next_st.refIdle = '0;
    end else if (st.refIdle != TW'(REF_TIMEOUT_CYCLES)) begin
      next_st.refIdle = st.refIdle + TW'(1);
    end
    next_st.refStable = (next_st.refIdle != TW'(REF_TIMEOUT_CYCLES));

    // lock acquisition
    unique case (st.lockState)
      pcs_pkg::PCS_IDLE: begin
        next_st.settleCnt = '0;
        if (enableRise) begin
          next_st.lockState = pcs_pkg::PCS_ACQUIRE;
        end
      end
      pcs_pkg::PCS_ACQUIRE: begin
        if (!st.refStable || !settingsValid) begin
          next_st.settleCnt = '0;
        end else if (refTick) begin
          if (st.settleCnt == SW'(LOCK_SETTLE_TICKS - 1)) begin
            next_st.lockState = pcs_pkg::PCS_LOCKED;
          end else begin
            next_st.settleCnt = st.settleCnt + SW'(1);
          end
        end
      end
      pcs_pkg::PCS_LOCKED: begin
        if (!st.refStable) begin
          next_st.lockState = pcs_pkg::PCS_ACQUIRE;
          next_st.settleCnt = '0;
        end
      end
      default: next_st.lockState = pcs_pkg::PCS_IDLE;
    endcase
    if (!next_st.enable) begin
      next_st.lockState = pcs_pkg::PCS_IDLE;
      next_st.settleCnt = '0;
    end
    next_st.lockFlag = (next_st.lockState == pcs_pkg::PCS_LOCKED);

    // read data, one cycle after the strobe
    if (regRd) begin
      unique case (regAddr)
        pcs_pkg::PCS_ADDR_FEEDBACK: next_st.rdData = {9'h000, st.fbStaged};
        pcs_pkg::PCS_ADDR_PRESCALE: next_st.rdData = {14'h0000, st.preStaged};
        pcs_pkg::PCS_ADDR_SOURCE: next_st.rdData = {15'h0000, st.srcStaged};
        pcs_pkg::PCS_ADDR_ENABLE: next_st.rdData = {15'h0000, st.enable};
        pcs_pkg::PCS_ADDR_LOCK: next_st.rdData = {15'h0000, st.lockFlag};
        pcs_pkg::PCS_ADDR_CLKOUT: next_st.rdData = {13'h0000, st.clkoutStaged};
        default: next_st.rdData = '0;
      endcase
    end

    if (srst) begin
      next_st = '0;
      next_st.fbStaged = pcs_pkg::PCS_FB_RESET;
      next_st.fbActive = pcs_pkg::PCS_FB_RESET;
      next_st.preStaged = pcs_pkg::PCS_PRE_RESET;
      next_st.preActive = pcs_pkg::PCS_PRE_RESET;
      next_st.srcStaged = pcs_pkg::PCS_SRC_RESET;
      next_st.srcActive = pcs_pkg::PCS_SRC_RESET;
      next_st.clkoutStaged = pcs_pkg::PCS_CLKOUT_RESET;
      next_st.clkoutActive = pcs_pkg::PCS_CLKOUT_RESET;
      next_st.refIdle = TW'(REF_TIMEOUT_CYCLES);
      next_st.lockState = pcs_pkg::PCS_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    st <= next_st;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign regRdData = st.rdData;
  assign pllClockRun = st.pllRun;
  assign coreClockSourceSel = st.srcActive;
  assign feedbackMultiplier = st.fbActive;
  assign activePrescale = st.preActive;
  assign clkoutEnable = st.clkoutActive[pcs_pkg::PCS_CLKOUT_EN_BIT];
  assign clkoutRate = st.clkoutActive[2:1];
  assign pllLockFlag = st.lockFlag;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cbAst @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  sequence seqEnableRise;
    regWr && regAddr == pcs_pkg::PCS_ADDR_ENABLE && regWrData[0] && !st.enable;
  endsequence

  sequence seqStagedWrite;
    regWr && st.enable && (regAddr == pcs_pkg::PCS_ADDR_FEEDBACK
      || regAddr == pcs_pkg::PCS_ADDR_PRESCALE || regAddr == pcs_pkg::PCS_ADDR_SOURCE);
  endsequence

  AST_APPLY_ON_RISE: assert property (
    seqEnableRise |=> (feedbackMultiplier == $past(st.fbStaged))
      && (activePrescale == $past(st.preStaged))
      && (coreClockSourceSel == $past(st.srcStaged)))
    else $error("staged settings not applied on enable rise");

  AST_STAGED_HOLD: assert property (
    seqStagedWrite |=> $stable(feedbackMultiplier) && $stable(activePrescale)
      && $stable(coreClockSourceSel))
    else $error("active settings changed without an enable rise");

  AST_SOURCE_ONLY_ON_RISE: assert property (
    $changed(coreClockSourceSel) |-> $past(enableRise))
    else $error("source select changed outside an enable rise");

  AST_NO_RUN_DISABLED: assert property (
    (regWr && regAddr == pcs_pkg::PCS_ADDR_ENABLE && !regWrData[0]) |=> !pllClockRun [*1])
    else $error("pll clock still running after disable");

  AST_LOCK_NEEDS_ENABLE: assert property (
    (st.lockState != pcs_pkg::PCS_IDLE) |-> st.enable && pllClockRun)
    else $error("lock attempted while disabled");

  AST_RELOCK_CLEARS: assert property (
    seqEnableRise |=> !pllLockFlag [*2])
    else $error("lock flag set during reconfiguration");

  AST_LOCK_PREREQ: assert property (
    $rose(pllLockFlag) |-> $past(st.refStable) && settingsValid && st.enable
      && $past(refTick))
    else $error("lock flag set without its prerequisites");

  AST_LOCK_READBACK: assert property (
    (regRd && regAddr == pcs_pkg::PCS_ADDR_LOCK) |=> regRdData == {15'h0000, $past(pllLockFlag)})
    else $error("lock register read returned wrong value");

  AST_LOCK_WRITE_IGNORED: assert property (
    (regWr && regAddr == pcs_pkg::PCS_ADDR_LOCK && st.lockState == pcs_pkg::PCS_IDLE)
      |=> !pllLockFlag)
    else $error("write to lock register changed the flag");

  sequence seqDisableWrite;
    regWr && regAddr == pcs_pkg::PCS_ADDR_ENABLE && !regWrData[pcs_pkg::PCS_ENABLE_BIT];
  endsequence

  sequence seqRefTimedOut;
    st.refIdle == TW'(REF_TIMEOUT_CYCLES);
  endsequence

  AST_CLKOUT_APPLY: assert property (
    seqEnableRise |=> (clkoutEnable == $past(st.clkoutStaged[pcs_pkg::PCS_CLKOUT_EN_BIT]))
      && (clkoutRate == $past(st.clkoutStaged[2:1])))
    else $error("clock output settings not applied on enable rise");

  AST_DISABLE_CLEARS_LOCK: assert property (
    seqDisableWrite |=> !pllLockFlag)
    else $error("lock flag still set after disable");

  AST_RUN_ON_ENABLE: assert property (
    (regWr && regAddr == pcs_pkg::PCS_ADDR_ENABLE && regWrData[pcs_pkg::PCS_ENABLE_BIT])
      |=> pllClockRun)
    else $error("pll clock not running after enable");

  AST_REF_LOSS_DROPS: assert property (
    seqRefTimedOut |=> !pllLockFlag)
    else $error("lock flag held without a stable reference");

  AST_LOCK_NEEDS_MULT: assert property (
    pllLockFlag |-> (feedbackMultiplier != '0))
    else $error("lock flag set with a zero multiplier");

  AST_LOCK_FROM_ACQUIRE: assert property (
    $rose(pllLockFlag) |-> ($past(st.lockState) == pcs_pkg::PCS_ACQUIRE))
    else $error("lock flag rose without an acquisition phase");

  AST_RDDATA_IDLE_ZERO: assert property (
    !regRd |=> (regRdData == '0))
    else $error("read data present without a read strobe");

endmodule : pcs_pll_clock_setup

`default_nettype wire

/* File: bench/pcs_mclk_model.sv */
// external master clock source feeding the master clock pin
`timescale 1ns/100ps
`default_nettype none

module pcs_mclk_model #(
  parameter int HALF_NS = 55
) (
  input wire logic run,
  output logic masterClockInputPin
);
  // ----------------------------------------------------------------
  // free oscillator, held low while stopped
  // ----------------------------------------------------------------
  initial masterClockInputPin = 1'b0;
  always begin
    #(HALF_NS);
    masterClockInputPin = run ? ~masterClockInputPin : 1'b0;
  end
endmodule : pcs_mclk_model

`default_nettype wire

/* File: bench/pcs_pll_clock_setup_tb.sv */
// self-checking testbench for the pll clock setup control block
`timescale 1ns/100ps
`default_nettype none

module pcs_pll_clock_setup_tb;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [15:0] regAddr = 16'h0000;
  logic [15:0] regWrData = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic run = 1'b0;
  logic masterClockInputPin;
  logic [15:0] regRdData;
  logic pllClockRun, coreClockSourceSel, clkoutEnable, pllLockFlag;
  logic [6:0] feedbackMultiplier;
  logic [1:0] activePrescale, clkoutRate;
  logic [12:0] act;
  int num_errors = 0;
  int cmp_count = 0;

  assign act = {coreClockSourceSel, clkoutEnable, clkoutRate, activePrescale, feedbackMultiplier};

  always #12.5 ref_clk = ~ref_clk;

  pcs_mclk_model u_src (.run(run), .masterClockInputPin(masterClockInputPin));

  pcs_pll_clock_setup #(.REF_TIMEOUT_CYCLES(80), .LOCK_SETTLE_TICKS(4)) u_dut (
    .ref_clk(ref_clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .masterClockInputPin(masterClockInputPin), .pllClockRun(pllClockRun),
    .coreClockSourceSel(coreClockSourceSel), .feedbackMultiplier(feedbackMultiplier),
    .activePrescale(activePrescale), .clkoutEnable(clkoutEnable),
    .clkoutRate(clkoutRate), .pllLockFlag(pllLockFlag));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic bus_wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    d = regRdData;
  endtask : bus_rd

  task automatic wait_lock(input int lim, output int n);
    n = 0;
    while (pllLockFlag !== 1'b1 && n < lim) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask : wait_lock

  task automatic step;
    @(posedge ref_clk);
    #1;
  endtask : step

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [15:0] d;
    check({3'h0, act}, 16'h0060);
    check({14'h0, pllClockRun, pllLockFlag}, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      bus_rd(16'hf000 + 16'(i), d);
      check(d, (i == 0) ? 16'h0060 : 16'h0000);
    end
  endtask : t_reset

  task automatic t_staging;
    logic [15:0] d;
    bus_wr(16'hf000, 16'h0025);
    bus_wr(16'hf001, 16'hffff);
    bus_wr(16'hf002, 16'h0001);
    bus_wr(16'hf005, 16'h0007);
    repeat (3) step();
    check({3'h0, act}, 16'h0060);
    bus_rd(16'hf001, d);
    check(d, 16'h0003);
    bus_rd(16'hf000, d);
    check(d, 16'h0025);
    bus_wr(16'hf003, 16'h0001);
    step();
    check({3'h0, act}, 16'h1fa5);
    check({15'h0, pllClockRun}, 16'h0001);
    bus_wr(16'hf000, 16'h0011);
    bus_wr(16'hf003, 16'h0001);
    repeat (3) step();
    check({3'h0, act}, 16'h1fa5);
    bus_wr(16'hf003, 16'h0000);
    step();
    check({15'h0, pllClockRun}, 16'h0000);
  endtask : t_staging

  task automatic t_no_lock_disabled;
    int n;
    run = 1'b1;
    wait_lock(200, n);
    check({15'h0, pllLockFlag}, 16'h0000);
  endtask : t_no_lock_disabled

  task automatic t_prescale;
    logic [15:0] d;
    int n, lo, hi;
    for (int p = 0; p < 4; p++) begin
      bus_wr(16'hf000, 16'h0060);
      bus_wr(16'hf001, 16'(p));
      bus_wr(16'hf002, 16'(p % 2));
      bus_wr(16'hf003, 16'h0001);
      step();
      check({14'h0, activePrescale}, 16'(p));
      check({15'h0, coreClockSourceSel}, 16'(p % 2));
      lo = (3 << p) * 44 / 10;
      hi = ((4 << p) + 3) * 44 / 10 + 12;
      wait_lock(300, n);
      check({15'h0, n >= lo && n <= hi}, 16'h0001);
      bus_rd(16'hf004, d);
      check(d, 16'h0001);
      bus_wr(16'hf004, 16'h0000);
      bus_rd(16'hf004, d);
      check(d, 16'h0001);
      bus_wr(16'hf003, 16'h0000);
      step();
      check({15'h0, pllLockFlag}, 16'h0000);
    end
  endtask : t_prescale

  task automatic t_zero_mult;
    int n;
    bus_wr(16'hf000, 16'h0000);
    bus_wr(16'hf001, 16'h0000);
    bus_wr(16'hf003, 16'h0001);
    wait_lock(200, n);
    check({15'h0, pllLockFlag}, 16'h0000);
    bus_wr(16'hf003, 16'h0000);
  endtask : t_zero_mult

  task automatic t_ref_loss;
    int n;
    bus_wr(16'hf000, 16'h0060);
    bus_wr(16'hf003, 16'h0001);
    wait_lock(60, n);
    check({15'h0, pllLockFlag}, 16'h0001);
    run = 1'b0;
    n = 0;
    while (pllLockFlag !== 1'b0 && n < 100) begin
      step();
      n++;
    end
    check({15'h0, pllLockFlag}, 16'h0000);
    repeat (100) step();
    check({15'h0, pllLockFlag}, 16'h0000);
    run = 1'b1;
    wait_lock(80, n);
    check({15'h0, pllLockFlag}, 16'h0001);
    bus_wr(16'hf003, 16'h0000);
  endtask : t_ref_loss

  // ----------------------------------------------------------------
  // verdict and main sequence
  // ----------------------------------------------------------------
  task automatic final_report;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  initial begin
    #(25 * 20000);
    num_errors++;
    final_report();
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    step();
    t_reset();
    t_staging();
    t_no_lock_disabled();
    t_prescale();
    t_zero_mult();
    t_ref_loss();
    final_report();
  end
endmodule : pcs_pll_clock_setup_tb

`default_nettype wire
